// ### dv/supply_partner.sv
// partner model: ring oscillator ticks and rail voltage comparators
`timescale 1ns/1ps
module supply_partner
#(
    parameter int TICK_DIV = 4,
    parameter int RAMP     = 6
)
(
    input  wire logic       clk_sys,
    input  wire logic       boost_enable,
    input  wire logic       ldo_enable,
    input  wire logic       rail_fault,
    output logic            ring_osc_tick,
    output logic      [1:0] rail_min_ok
);
    int div_cnt  = 0;
    int ramp_cnt = 0;

    initial ring_osc_tick = 1'b0;
    initial rail_min_ok = 2'h0;

    // free running: the oscillator is powered from either supply
    always @(posedge clk_sys)
    begin
        div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
        ring_osc_tick <= (div_cnt == TICK_DIV - 1);
    end

    // 3.3 v climbs first, so a lone good comparator is seen for a while
    always @(posedge clk_sys)
    begin
        if (!(boost_enable || ldo_enable) || rail_fault)
            ramp_cnt <= 0;
        else if (ramp_cnt < RAMP)
            ramp_cnt <= ramp_cnt + 1;
        rail_min_ok[0] <= (ramp_cnt >= RAMP / 2) && !rail_fault;
        rail_min_ok[1] <= (ramp_cnt >= RAMP) && !rail_fault;
    end
endmodule

// ### dv/tb_top.sv
// self-checking bench of the power supply sequencer
`timescale 1ns/1ps
module tb_top;
    // hold count follows the shortened oscillator rate given to the dut
    localparam int OSC_KHZ = 8;
    localparam int HOLD    = OSC_KHZ;

    logic        clk_sys = 1'b0;
    logic        srst, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic        start_in, stop_in, usb_present, batt_present, rail_fault;
    logic        ring_osc_tick, boost_enable, ldo_enable, local_from_usb;
    logic        ref_power_on, rails_good, int_reset_n, conv_clk_sel;
    logic [1:0]  rail_min_ok, rail_low, rail_high, boost_raise, boost_lower;
    logic [2:0]  boost_trim_3v3, boost_trim_1v8;
    int          err_count = 0;
    int          n_checks  = 0;
    int          cycles    = 0;
    bit          go        = 1'b0;
    int          m_st, m_prev, m_cnt;
    bit          m_sp, m_pp, m_up, m_rg, m_usb, m_bat;
    logic [1:0]  m_lo, m_hi;
    logic [2:0]  m_t3 = 3'h3;
    logic [2:0]  m_t1 = 3'h1;

    power_supply_sequencer #(.RING_OSC_KHZ(OSC_KHZ)) dut
    (
        .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .start_in(start_in),
        .stop_in(stop_in), .usb_present(usb_present),
        .batt_present(batt_present), .ring_osc_tick(ring_osc_tick),
        .rail_min_ok(rail_min_ok), .rail_low(rail_low),
        .rail_high(rail_high), .boost_enable(boost_enable),
        .ldo_enable(ldo_enable), .local_from_usb(local_from_usb),
        .ref_power_on(ref_power_on), .rails_good(rails_good),
        .int_reset_n(int_reset_n), .conv_clk_sel(conv_clk_sel),
        .boost_trim_3v3(boost_trim_3v3), .boost_trim_1v8(boost_trim_1v8),
        .boost_raise(boost_raise), .boost_lower(boost_lower)
    );

    supply_partner partner
    (
        .clk_sys(clk_sys), .boost_enable(boost_enable),
        .ldo_enable(ldo_enable), .rail_fault(rail_fault),
        .ring_osc_tick(ring_osc_tick), .rail_min_ok(rail_min_ok)
    );

    always #5 clk_sys = ~clk_sys;

    // reference model: 0 off, 1 boost, 2 linear regulators
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            {m_st, m_prev, m_cnt} = '0;
            {m_sp, m_pp, m_up, m_rg, m_usb, m_bat} = '0;
        end
        else
        begin
            m_prev = m_st;
            if (!m_rg)
                m_cnt = 0;
            else if (ring_osc_tick)
                m_cnt++;
            if (m_st == 0 && usb_present && !m_up)
                m_st = 2;
            else if (m_st == 0 && m_sp && !start_in && batt_present
                     && !usb_present)
                m_st = 1;
            else if (m_st != 0 && stop_in && !m_pp)
                m_st = 0;
            else if (m_st == 1 && usb_present)
                m_st = 2;
            else if (m_st == 2 && !usb_present)
                m_st = 0;
            m_rg = (m_st != 0) && (rail_min_ok == 2'h3);
            {m_sp, m_pp, m_up} = {start_in, stop_in, usb_present};
            {m_usb, m_bat, m_lo, m_hi} = {usb_present, batt_present,
                                          rail_low, rail_high};
        end
    end

    always @(negedge clk_sys)
    if (go)
    begin
        chk_bit(boost_enable, m_st == 1);
        chk_bit(ldo_enable, m_st == 2);
        chk_bit(rails_good, m_rg);
        chk_bit(local_from_usb, m_usb);
        chk_bit(ref_power_on, m_usb | m_bat);
        chk_word({29'h0, boost_trim_3v3}, {29'h0, m_t3});
        chk_word({29'h0, boost_trim_1v8}, {29'h0, m_t1});
        if (m_st == 0 && m_prev == 0)
        begin
            chk_bit(int_reset_n, 1'b0);
            chk_bit(conv_clk_sel, 1'b0);
        end
        if (m_st == m_prev && m_st != 0)
        begin
            chk_word({30'h0, boost_raise},
                     {30'h0, (m_st == 1) ? (m_lo & ~m_hi) : 2'h0});
            chk_word({30'h0, boost_lower},
                     {30'h0, (m_st == 1) ? (m_hi & ~m_lo) : 2'h0});
        end
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_count++;
            summarize();
        end
    end

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // rail regulation comparators wander at random every cycle
    task automatic cyc(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            rail_low <= 2'($urandom);
            rail_high <= 2'($urandom);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int g;
        g = 0;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && g < 20)
        begin
            @(posedge clk_sys);
            g++;
        end
        if (g == 20)
            err_count++;
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (w && a == power_seq_pkg::ADDR_RAIL3V3_TRIM)
            m_t3 = wd[2:0];
        if (w && a == power_seq_pkg::ADDR_RAIL1V8_TRIM)
            m_t1 = wd[2:0];
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp,
                          input logic experr);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        chk_word(rd, exp);
        chk_bit(er, experr);
    endtask

    // reset and clock select stay low until the full hold has been counted
    task automatic wait_release();
        int g;
        g = 0;
        while (g < 400)
        begin
            @(negedge clk_sys);
            if (m_cnt >= HOLD)
                break;
            chk_bit(int_reset_n, 1'b0);
            chk_bit(conv_clk_sel, 1'b0);
            g++;
        end
        cyc(6);
        @(negedge clk_sys);
        chk_bit(int_reset_n, 1'b1);
        cyc(1);
    endtask

    initial
    begin
        logic [31:0] v;
        logic [31:0] rd;
        logic        er;
        {srst, psel, penable, pwrite, paddr, pwdata} = {4'b1000, 64'h0};
        {start_in, stop_in, usb_present, batt_present} = 4'b1001;
        {rail_fault, rail_low, rail_high} = 5'h0;
        v = $urandom(3636);
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        go = 1'b1;
        rd_chk(power_seq_pkg::ADDR_RAIL3V3_TRIM, 32'h3, 1'b0);
        rd_chk(power_seq_pkg::ADDR_RAIL1V8_TRIM, 32'h1, 1'b0);
        rd_chk(power_seq_pkg::ADDR_CONV_CLK_SEL, 32'h0, 1'b0);
        apb(1'b1, 32'h8000_5010, 32'h7, rd, er);
        chk_bit(er, 1'b1);
        rd_chk(32'h8000_5000, 32'h0, 1'b1);
        apb(1'b1, power_seq_pkg::ADDR_RAIL1V8_TRIM, 32'hffff_fffd, rd, er);
        rd_chk(power_seq_pkg::ADDR_RAIL1V8_TRIM, 32'h5, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            v = $urandom;
            apb(1'b1, power_seq_pkg::ADDR_RAIL3V3_TRIM, i, rd, er);
            apb(1'b1, power_seq_pkg::ADDR_RAIL1V8_TRIM, v & 7, rd, er);
            rd_chk(power_seq_pkg::ADDR_RAIL3V3_TRIM, i, 1'b0);
            rd_chk(power_seq_pkg::ADDR_RAIL1V8_TRIM, v & 7, 1'b0);
        end
        batt_present <= 1'b0;
        cyc(2);
        start_in <= 1'b0;
        cyc(4);
        {start_in, batt_present} <= 2'b11;
        cyc(4);
        start_in <= 1'b0;
        cyc(20);
        rail_fault <= 1'b1;
        cyc(3);
        rail_fault <= 1'b0;
        wait_release();
        apb(1'b1, power_seq_pkg::ADDR_CONV_CLK_SEL, 32'h1, rd, er);
        cyc(2);
        @(negedge clk_sys);
        chk_bit(conv_clk_sel, 1'b1);
        cyc(1);
        start_in <= 1'b1;
        cyc(3);
        start_in <= 1'b0;
        cyc(30);
        usb_present <= 1'b1;
        cyc(20);
        usb_present <= 1'b0;
        cyc(6);
        usb_present <= 1'b1;
        wait_release();
        stop_in <= 1'b1;
        cyc(5);
        {stop_in, usb_present, start_in} <= 3'b001;
        cyc(4);
        start_in <= 1'b0;
        wait_release();
        stop_in <= 1'b1;
        cyc(6);
        summarize();
    end
endmodule

// ### pkg/power_seq_pkg.sv
// constants, types and register map of the power supply sequencer
package power_seq_pkg;

    // register byte addresses on the apb bus
    localparam logic [31:0] ADDR_RAIL3V3_TRIM = 32'h8000_5004;
    localparam logic [31:0] ADDR_RAIL1V8_TRIM = 32'h8000_5008;
    localparam logic [31:0] ADDR_CONV_CLK_SEL = 32'h8000_500c;

    // field layout and reset values
    localparam int          TRIM_W            = 3;
    localparam logic [2:0]  RAIL3V3_TRIM_RST  = 3'h3;
    localparam logic [2:0]  RAIL1V8_TRIM_RST  = 3'h1;
    localparam logic        CONV_CLK_SEL_RST  = 1'b0;
    localparam int          CLK_SEL_BIT       = 0;
    localparam logic [31:0] RDATA_ZERO        = 32'h0000_0000;

    // rail indices for the per-rail comparator vectors
    localparam int          NUM_RAILS         = 2;
    localparam int          RAIL_3V3          = 0;
    localparam int          RAIL_1V8          = 1;

    // reset hold time and the ring oscillator rate it is counted in
    localparam int          RESET_HOLD_US     = 1000;
    localparam int          RING_OSC_KHZ_DEF  = 1000;
    localparam int          CNT_W             = 16;

    typedef enum logic [1:0] {
        SEQ_OFF,
        SEQ_BOOST,
        SEQ_LDO
    } seq_state_type;

    typedef struct packed {
        seq_state_type         state;
        logic                  start_prev;
        logic                  stop_prev;
        logic                  usb_prev;
        logic [TRIM_W-1:0]     trim3v3;
        logic [TRIM_W-1:0]     trim1v8;
        logic                  clk_sel;
        logic                  boost_en;
        logic                  ldo_en;
        logic                  local_usb;
        logic                  ref_on;
        logic                  rails_good;
        logic                  int_reset_n;
        logic                  conv_clk_sel;
        logic [NUM_RAILS-1:0]  raise;
        logic [NUM_RAILS-1:0]  lower;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
    } seq_regs_type;

    typedef struct packed {
        logic [CNT_W-1:0]      cnt;
        logic                  done;
    } timer_regs_type;

endpackage

// ### pkg/reset_timer_if.sv
// carrier between the sequencer and its reset hold timer
`timescale 1ns/1ps
interface reset_timer_if;
    logic rails_good;
    logic osc_tick;
    logic done;

    modport ctrl  (output rails_good, output osc_tick, input done);
    modport timer (input rails_good, input osc_tick, output done);
endinterface

// ### rtl/power_supply_sequencer.sv
// power supply sequencer: start/stop, usb priority, reset hold, apb regs
//
// Function
// - off on battery only, falling start edge enables boost converters.
// - rails_good only when both 1.8 V and 3.3 V comparators report ok.
// - internal reset held about 1 ms of ring ticks after rails_good.
// - once converters run, further start edges are ignored.
// - rising stop edge shuts converters off and asserts internal reset; while off it is ignored, so a same-cycle start or usb edge still starts them.
// - usb appearing while off starts up, reset held about 1 ms.
// - usb removal makes an automatic stop, same as a stop edge.
// - usb arriving in battery run swaps boost for linear regulators.
// - usb power is always preferred over battery.
// - usb removed after changeover stops, never falls back to battery.
// - converters run from ring oscillator until reset is released and software selects 12 MHz.
// - reference on with usb or battery; local supply from usb if present.
// - while boosting, outputs are checked and kept in range.
// - trim values steer only the boost converters, not linear regulators.
// - 3.3 V trim is bits 2:0, resets to 011, upper bits reserved.
// - higher 3.3 V trim code selects lower output voltage.
// - 1.8 V trim is 3-bit read/write, resets to 1.
// - clock select is one read/write bit, 0 ring oscillator, 1 12 MHz.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module power_supply_sequencer
#(
    parameter int RING_OSC_KHZ = power_seq_pkg::RING_OSC_KHZ_DEF
)
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // switches, supply detect and comparators
    input  wire logic        start_in,
    input  wire logic        stop_in,
    input  wire logic        usb_present,
    input  wire logic        batt_present,
    input  wire logic        ring_osc_tick,
    input  wire logic [1:0]  rail_min_ok,
    input  wire logic [1:0]  rail_low,
    input  wire logic [1:0]  rail_high,
    // power control outputs
    output logic             boost_enable,
    output logic             ldo_enable,
    output logic             local_from_usb,
    output logic             ref_power_on,
    output logic             rails_good,
    output logic             int_reset_n,
    output logic             conv_clk_sel,
    output logic      [2:0]  boost_trim_3v3,
    output logic      [2:0]  boost_trim_1v8,
    output logic      [1:0]  boost_raise,
    output logic      [1:0]  boost_lower
);

    // hold time in ring ticks, rounded down, at least one tick
    localparam int HOLD_TICKS_INT =
        (power_seq_pkg::RESET_HOLD_US * RING_OSC_KHZ) / 1000;
    localparam logic [15:0] HOLD_TICKS =
        (HOLD_TICKS_INT < 1) ? 16'h0001 : 16'(HOLD_TICKS_INT);

    power_seq_pkg::seq_regs_type seq_reg;
    power_seq_pkg::seq_regs_type seq_next;

    reset_timer_if tmr_if ();

    logic                 start_fall;
    logic                 stop_rise;
    logic                 usb_rise;
    logic                 usb_fall;
    logic                 apb_setup;
    logic                 apb_write;
    logic                 running;
    logic [1:0]           adj_up;
    logic [1:0]           adj_dn;

    reset_delay_timer #(
        .HOLD_TICKS (HOLD_TICKS)
    ) u_timer (
        .clk_sys (clk_sys),
        .srst    (srst),
        .tmr     (tmr_if.timer)
    );

    // the timer sees the registered rails_good, so the hold spans full ticks
    assign tmr_if.rails_good = seq_reg.rails_good;
    assign tmr_if.osc_tick   = ring_osc_tick;

    assign start_fall = seq_reg.start_prev && !start_in;
    assign stop_rise  = !seq_reg.stop_prev && stop_in;
    assign usb_rise   = !seq_reg.usb_prev && usb_present;
    assign usb_fall   = seq_reg.usb_prev && !usb_present;
    assign apb_setup  = psel && !penable;
    assign apb_write  = psel && penable && seq_reg.pready && pwrite;

    // per-rail window check: nudge up when low, down when high
    generate
        for (genvar i = 0; i < power_seq_pkg::NUM_RAILS; i++)
        begin : g_rail
            assign adj_up[i] = rail_low[i] && !rail_high[i];
            assign adj_dn[i] = rail_high[i] && !rail_low[i];
        end
    endgenerate

    always_comb
    begin
        seq_next            = seq_reg;
        seq_next.start_prev = start_in;
        seq_next.stop_prev  = stop_in;
        seq_next.usb_prev   = usb_present;

        case (seq_reg.state)
            power_seq_pkg::SEQ_OFF:
            begin
                // usb checked first so it wins a same-cycle start edge
                if (usb_rise)
                begin
                    seq_next.state = power_seq_pkg::SEQ_LDO;
                end
                else if (start_fall && batt_present && !usb_present)
                begin
                    seq_next.state = power_seq_pkg::SEQ_BOOST;
                end
            end
            power_seq_pkg::SEQ_BOOST:
            begin
                // start edges fall through here untouched
                if (stop_rise)
                begin
                    seq_next.state = power_seq_pkg::SEQ_OFF;
                end
                else if (usb_present)
                begin
                    seq_next.state = power_seq_pkg::SEQ_LDO;
                end
            end
            power_seq_pkg::SEQ_LDO:
            begin
                // no way back to boost: a lost usb supply means off
                if (stop_rise || usb_fall || !usb_present)
                begin
                    seq_next.state = power_seq_pkg::SEQ_OFF;
                end
            end
            default:
            begin
                seq_next.state = power_seq_pkg::SEQ_OFF;
            end
        endcase

        running = seq_next.state != power_seq_pkg::SEQ_OFF;

        seq_next.boost_en  = seq_next.state == power_seq_pkg::SEQ_BOOST;
        seq_next.ldo_en    = seq_next.state == power_seq_pkg::SEQ_LDO;
        seq_next.ref_on    = usb_present || batt_present;
        seq_next.local_usb = usb_present;

        seq_next.rails_good = running && (&rail_min_ok);
        // timer done is cleared by the rails_good drop that a stop causes
        seq_next.int_reset_n = running && seq_reg.rails_good
                               && tmr_if.done;

        // regulation only while boosting; linear regulators run untrimmed
        seq_next.raise = seq_next.boost_en ? adj_up : 2'h0;
        seq_next.lower = seq_next.boost_en ? adj_dn : 2'h0;

        // ring oscillator until reset is released
        seq_next.conv_clk_sel = seq_reg.clk_sel && seq_next.int_reset_n;

        // apb: decode in setup, answer in access with one wait-free phase
        seq_next.pready = apb_setup;
        if (apb_setup)
        begin
            seq_next.pslverr = 1'b0;
            // reserved bits read as zero
            case (paddr)
                power_seq_pkg::ADDR_RAIL3V3_TRIM:
                    seq_next.prdata = {29'h0, seq_reg.trim3v3};
                power_seq_pkg::ADDR_RAIL1V8_TRIM:
                    seq_next.prdata = {29'h0, seq_reg.trim1v8};
                power_seq_pkg::ADDR_CONV_CLK_SEL:
                    seq_next.prdata = {31'h0, seq_reg.clk_sel};
                default:
                begin
                    seq_next.prdata  = power_seq_pkg::RDATA_ZERO;
                    seq_next.pslverr = 1'b1;
                end
            endcase
        end
        else
        begin
            seq_next.prdata  = power_seq_pkg::RDATA_ZERO;
            seq_next.pslverr = 1'b0;
        end

        if (apb_write)
        begin
            // only the field bits are stored; reserved writes are dropped
            case (paddr)
                power_seq_pkg::ADDR_RAIL3V3_TRIM:
                    seq_next.trim3v3 = pwdata[2:0];
                power_seq_pkg::ADDR_RAIL1V8_TRIM:
                    seq_next.trim1v8 = pwdata[2:0];
                power_seq_pkg::ADDR_CONV_CLK_SEL:
                    // caller must have a stable 12 MHz first
                    seq_next.clk_sel =
                        pwdata[power_seq_pkg::CLK_SEL_BIT];
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            seq_reg         <= '0;
            seq_reg.state   <= power_seq_pkg::SEQ_OFF;
            seq_reg.trim3v3 <= power_seq_pkg::RAIL3V3_TRIM_RST;
            seq_reg.trim1v8 <= power_seq_pkg::RAIL1V8_TRIM_RST;
            seq_reg.clk_sel <= power_seq_pkg::CONV_CLK_SEL_RST;
        end
        else
        begin
            seq_reg <= seq_next;
        end
    end

    assign prdata         = seq_reg.prdata;
    assign pready         = seq_reg.pready;
    assign pslverr        = seq_reg.pslverr;
    assign boost_enable   = seq_reg.boost_en;
    assign ldo_enable     = seq_reg.ldo_en;
    assign local_from_usb = seq_reg.local_usb;
    assign ref_power_on   = seq_reg.ref_on;
    assign rails_good     = seq_reg.rails_good;
    assign int_reset_n    = seq_reg.int_reset_n;
    assign conv_clk_sel   = seq_reg.conv_clk_sel;
    // code 0 is the highest voltage, each step lower
    assign boost_trim_3v3 = seq_reg.trim3v3;
    assign boost_trim_1v8 = seq_reg.trim1v8;
    assign boost_raise    = seq_reg.raise;
    assign boost_lower    = seq_reg.lower;

    a_start_boost: assert property (
        @(posedge clk_sys) disable iff (srst)
        (seq_reg.state == power_seq_pkg::SEQ_OFF) && start_fall
        && batt_present && !usb_present && !usb_rise
        |=> boost_enable && !ldo_enable)
        else $error("start edge on battery did not enable boost");

    a_rails_good_cmp: assert property (
        @(posedge clk_sys) disable iff (srst)
        rails_good |-> $past(&rail_min_ok))
        else $error("rails_good without both comparators ok");

    a_reset_hold: assert property (
        @(posedge clk_sys) disable iff (srst)
        $rose(int_reset_n) |-> $past(rails_good, 2) && $past(tmr_if.done))
        else $error("internal reset released without hold");

    a_start_ignored: assert property (
        @(posedge clk_sys) disable iff (srst)
        (seq_reg.state == power_seq_pkg::SEQ_BOOST) && start_fall
        && !stop_rise && !usb_present
        |=> seq_reg.state == power_seq_pkg::SEQ_BOOST)
        else $error("start edge disturbed running boost");

    a_stop_shutoff: assert property (
        @(posedge clk_sys) disable iff (srst)
        stop_rise |=> !boost_enable && !ldo_enable && !int_reset_n)
        else $error("stop edge did not shut off and reset");

    a_usb_autostart: assert property (
        @(posedge clk_sys) disable iff (srst)
        (seq_reg.state == power_seq_pkg::SEQ_OFF) && usb_rise
        |=> ldo_enable ##1 !int_reset_n)
        else $error("usb arrival did not start with reset held");

    a_usb_stop: assert property (
        @(posedge clk_sys) disable iff (srst)
        (seq_reg.state == power_seq_pkg::SEQ_LDO) && usb_fall
        |=> !boost_enable && !ldo_enable ##1 !boost_enable)
        else $error("usb removal did not stop the device");

    a_usb_changeover: assert property (
        @(posedge clk_sys) disable iff (srst)
        (seq_reg.state == power_seq_pkg::SEQ_BOOST) && usb_present
        && !stop_rise |=> ldo_enable && !boost_enable)
        else $error("usb during battery run did not change over");

    a_clksel_startup: assert property (
        @(posedge clk_sys) disable iff (srst)
        conv_clk_sel |-> int_reset_n && $past(seq_reg.clk_sel))
        else $error("12 MHz selected during start-up");

    a_local_supply: assert property (
        @(posedge clk_sys) disable iff (srst)
        !srst && (usb_present || batt_present) |=> ref_power_on
        && (local_from_usb == $past(usb_present)))
        else $error("local supply selection wrong");

    a_trim_boost_only: assert property (
        @(posedge clk_sys) disable iff (srst)
        (boost_raise != 2'h0 || boost_lower != 2'h0) |-> boost_enable)
        else $error("regulation adjust outside boost mode");

    a_trim_write: assert property (
        @(posedge clk_sys) disable iff (srst)
        apb_write && (paddr == power_seq_pkg::ADDR_RAIL3V3_TRIM)
        |=> boost_trim_3v3 == $past(pwdata[2:0]))
        else $error("3.3 V trim write not stored");

    a_apb_answer: assert property (
        @(posedge clk_sys) disable iff (srst)
        apb_setup |=> pready ##1 !pready || (psel && !penable))
        else $error("apb answer not in access phase");

    a_usb_priority: assert property (
        @(posedge clk_sys) disable iff (srst)
        (seq_reg.state != power_seq_pkg::SEQ_OFF) && usb_present
        && !stop_rise |=> ldo_enable && !boost_enable)
        else $error("usb present but boost still selected");

    a_ldo_no_boost: assert property (
        @(posedge clk_sys) disable iff (srst)
        (seq_reg.state == power_seq_pkg::SEQ_LDO) |=> !boost_enable)
        else $error("linear regulator run fell back to boost");

    a_clksel_write: assert property (
        @(posedge clk_sys) disable iff (srst)
        apb_write && (paddr == power_seq_pkg::ADDR_CONV_CLK_SEL)
        |=> seq_reg.clk_sel == $past(pwdata[power_seq_pkg::CLK_SEL_BIT]))
        else $error("clock select write not stored");

endmodule

// ### rtl/reset_delay_timer.sv
// counts ring oscillator ticks while the rails are good
`timescale 1ns/1ps
module reset_delay_timer
#(
    parameter logic [15:0] HOLD_TICKS = 16'h03e8
)
(
    input  wire logic     clk_sys,
    input  wire logic     srst,
    reset_timer_if.timer  tmr
);

    power_seq_pkg::timer_regs_type t_reg;
    power_seq_pkg::timer_regs_type t_next;

    assign tmr.done = t_reg.done;

    always_comb
    begin
        t_next = t_reg;
        if (!tmr.rails_good)
        begin
            // any dip starts the whole hold over
            t_next.cnt  = '0;
            t_next.done = 1'b0;
        end
        else if (tmr.osc_tick && !t_reg.done)
        begin
            t_next.cnt = t_reg.cnt + 16'h0001;
            if (t_next.cnt == HOLD_TICKS)
            begin
                t_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            t_reg <= '0;
        end
        else
        begin
            t_reg <= t_next;
        end
    end

    a_hold_count: assert property (
        @(posedge clk_sys) disable iff (srst)
        $rose(t_reg.done) |-> $past(t_reg.cnt) == HOLD_TICKS - 16'h0001)
        else $error("reset hold ended at wrong tick count");

    a_timer_restart: assert property (
        @(posedge clk_sys) disable iff (srst)
        !tmr.rails_good |=> (t_reg.cnt == '0) && !t_reg.done)
        else $error("hold timer did not restart on rail loss");

endmodule
